// ==== hw/ssp_stop_pkg.sv ====
// constants, register map and state types of the serial port stop/divider block
// assumes one 10 MHz system clock and an APB master with 32-bit data
// ==========================================================================
// How it works
// [RQ1] a stop first pulls the data line low and releases the clock line once data reads low
// [RQ2] during a stop the divider is loaded only after the released clock line reads high
// [RQ3] when the divider expires during a stop after data is released, a low data line flags a bus collision
// [RQ4] a clock line read low after it was seen high and before data is released flags a collision
// [RQ5] the divider is the serial clock source in two-wire master and spi master modes
// [RQ6] a software write to the shift buffer starts the divider with no other command
// [RQ7] when the operation ends the divider stops and the clock output keeps its level
// [RQ8] a reload strobe copies the reload register into the counter once per half period
// [RQ9] the conditions that raise the reload strobe are chosen by the operating mode
// [RQ10] serial clock is the system clock over four times reload plus one, two rollovers
// [RQ11] software keeps reload values 0x00 to 0x02 away from two-wire master use
// [RQ12] any bus collision sets the collision flag and returns the port to idle
// [RQ13] a collision aborts the sequence, releases both lines and clears the stop request
// [RQ14] a good stop sets stop seen, then one divider period after the divider next expires clears the request
// [RQ15] the counter is eight bits wide and a count of zero is the half-period timeout
package ssp_stop_pkg;
	// ======================================================================
	// register byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SEQ = 8'h04;
	localparam logic [7:0] OFS_RELOAD = 8'h08;
	localparam logic [7:0] OFS_BUF = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_EVT = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	// ======================================================================
	// field layout
	localparam int MODE_W = 4;
	localparam int CTRL_EN_BIT = 4;
	localparam int SEQ_STOP_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_STOP_BIT = 4;
	localparam int EV_W = 3;
	localparam int EV_SER = 0;
	localparam int EV_COLL = 1;
	localparam int EV_WCOL = 2;
	localparam int DIV_W = 8;
	localparam int HALF_W = 5;
	// ======================================================================
	// modes, reset values, counts
	localparam logic [MODE_W-1:0] MODE_I2C_MST = 4'h8;
	localparam logic [MODE_W-1:0] MODE_SPI_MST = 4'ha;
	localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
	localparam logic [DIV_W-1:0] RELOAD_RST = 8'h09;
	localparam logic [HALF_W-1:0] HALVES = 5'h10;
	localparam logic PRE_LAST = 1'b1;
	// ======================================================================
	// controller states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_STP_SDA,
		ST_STP_SCL,
		ST_STP_HIGH,
		ST_STP_REL,
		ST_STP_DONE,
		ST_XFER
	} state_t;
endpackage

// ==== hw/clock_divider.sv ====
// reloadable down counter that times each half period of the serial clock
// assumes load and run come from logic on the same clock
`timescale 1ns/1ps
module clock_divider
	import ssp_stop_pkg::*;
#(
	parameter int W = DIV_W
) (
	input wire logic ref_clk_i, // system clock
	input wire logic rst_n_i, // async reset, low
	input wire logic run_i, // count enable
	input wire logic load_i, // reload strobe
	input wire logic [W-1:0] reload_i, // reload value
	output logic expire_o // zero reached, one cycle
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic pre;
	} div_t;
	div_t st_ff;
	div_t nxt_st;

	// ======================================================================
	// two system clocks per count step gives four per reload unit per period
	assign expire_o = run_i && st_ff.cnt == '0 && st_ff.pre == PRE_LAST; // RQ15

	always_comb begin
		nxt_st = st_ff;
		if (load_i) begin
			nxt_st.cnt = reload_i; // RQ8
			nxt_st.pre = 1'b0;
		end else if (run_i) begin
			nxt_st.pre = !st_ff.pre;
			if (st_ff.pre == PRE_LAST && st_ff.cnt != '0) begin
				nxt_st.cnt = st_ff.cnt - 1'b1; // RQ10
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================================
	// half period is exactly 2*(reload+1) clocks
	a_half_period: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RQ10
		(load_i && reload_i == 8'h03 && run_i) ##1 (run_i && !load_i)[*7] |=> expire_o)
		else $error("divider half period wrong");
endmodule

// ==== hw/ssp_stop_ctrl.sv ====
// serial port master: clock divider, stop sequence with collision checks, apb registers
// assumes open-drain pads outside and an apb master on ref_clk_i
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module ssp_stop_ctrl
	import ssp_stop_pkg::*;
(
	input wire logic ref_clk_i, // 10 MHz system clock
	input wire logic rst_n_i, // async reset, low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb write
	input wire logic [7:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error, unmapped
	input wire logic scl_i, // clock line level
	output logic scl_o, // clock line drive value
	output logic scl_oe_n_o, // low: pull clock line low
	input wire logic sda_i, // data line level
	output logic sda_o, // data line drive value
	output logic sda_oe_n_o, // low: pull data line low
	output logic sck_o, // spi master clock
	output logic irq_o // level interrupt
);
	typedef struct packed {
		logic scl_meta;
		logic scl_s;
		logic sda_meta;
		logic sda_s;
		logic enable;
		logic [MODE_W-1:0] mode;
		logic [DIV_W-1:0] reload;
		logic [DIV_W-1:0] shbuf;
		logic stop_req;
		logic stop_seen;
		logic [EV_W-1:0] evt;
		logic [EV_W-1:0] mask;
		state_t state;
		logic scl_rel;
		logic sda_rel;
		logic sck;
		logic [HALF_W-1:0] halves;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} ctrl_t;

	ctrl_t st_ff;
	ctrl_t nxt_st;
	logic load;
	logic expire;
	logic wr;
	logic wr_buf;
	logic stop_go;
	logic coll;
	logic i2c_mst;
	logic spi_mst;
	logic [EV_W-1:0] ev_set;

	// ======================================================================
	// half-period timer, runs whenever a sequence is active
	clock_divider #(
		.W(DIV_W)
	) u_div (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(st_ff.state != ST_IDLE), // RQ7
		.load_i(load),
		.reload_i(st_ff.reload),
		.expire_o(expire)
	);

	// ======================================================================
	// next-state logic
	always_comb begin
		nxt_st = st_ff;
		load = 1'b0;
		coll = 1'b0;
		stop_go = 1'b0;
		ev_set = '0;
		i2c_mst = st_ff.mode == MODE_I2C_MST;
		spi_mst = st_ff.mode == MODE_SPI_MST;
		wr = psel_i && penable_i && pwrite_i && st_ff.pready;
		wr_buf = wr && paddr_i == OFS_BUF;
		// pins cross in from the bus; first stage feeds only the second
		nxt_st.scl_meta = scl_i;
		nxt_st.scl_s = st_ff.scl_meta;
		nxt_st.sda_meta = sda_i;
		nxt_st.sda_s = st_ff.sda_meta;
		// no wait state: ready is high in the first access cycle
		nxt_st.pready = psel_i && !penable_i;
		nxt_st.pslverr = 1'b0;
		nxt_st.prdata = '0;
		if (psel_i && !penable_i) begin
			case (paddr_i)
				OFS_CTRL: nxt_st.prdata[CTRL_EN_BIT:0] = {st_ff.enable, st_ff.mode};
				OFS_SEQ: nxt_st.prdata[SEQ_STOP_BIT] = st_ff.stop_req;
				OFS_RELOAD: nxt_st.prdata[DIV_W-1:0] = st_ff.reload;
				OFS_BUF: nxt_st.prdata[DIV_W-1:0] = st_ff.shbuf;
				OFS_STAT: begin
					nxt_st.prdata[STAT_STOP_BIT] = st_ff.stop_seen;
					nxt_st.prdata[STAT_BUSY_BIT] = st_ff.state != ST_IDLE;
				end
				OFS_EVT: nxt_st.prdata[EV_W-1:0] = st_ff.evt;
				OFS_MASK: nxt_st.prdata[EV_W-1:0] = st_ff.mask;
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
		// register writes; event bits clear on writing one
		if (wr) begin
			case (paddr_i)
				OFS_CTRL: {nxt_st.enable, nxt_st.mode} = pwdata_i[CTRL_EN_BIT:0];
				OFS_SEQ: stop_go = pwdata_i[SEQ_STOP_BIT];
				OFS_RELOAD: nxt_st.reload = pwdata_i[DIV_W-1:0]; // RQ11
				OFS_EVT: nxt_st.evt = st_ff.evt & ~pwdata_i[EV_W-1:0];
				OFS_MASK: nxt_st.mask = pwdata_i[EV_W-1:0];
				default: ;
			endcase
		end
		// buffer written while busy is dropped and flagged
		if (wr_buf && st_ff.state != ST_IDLE) begin
			ev_set[EV_WCOL] = 1'b1;
		end
		// sequencer
		case (st_ff.state)
			ST_IDLE: begin
				if (stop_go && st_ff.enable && i2c_mst) begin
					nxt_st.stop_req = 1'b1;
					nxt_st.stop_seen = 1'b0;
					nxt_st.sda_rel = 1'b0; // RQ1
					nxt_st.scl_rel = 1'b0; // RQ1
					nxt_st.state = ST_STP_SDA;
				end else if (wr_buf) begin
					nxt_st.shbuf = pwdata_i[DIV_W-1:0];
					if (st_ff.enable && (i2c_mst || spi_mst)) begin
						load = 1'b1; // RQ6
						nxt_st.halves = '0;
						nxt_st.state = ST_XFER; // RQ5
					end
				end
			end
			ST_STP_SDA: begin
				if (!st_ff.sda_s) begin
					nxt_st.scl_rel = 1'b1; // RQ1
					nxt_st.state = ST_STP_SCL;
				end
			end
			ST_STP_SCL: begin
				// a slave stretching the clock just delays the load
				if (st_ff.scl_s) begin
					load = 1'b1; // RQ2
					nxt_st.state = ST_STP_HIGH;
				end
			end
			ST_STP_HIGH: begin
				if (!st_ff.scl_s) begin
					coll = 1'b1; // RQ4
				end else if (expire) begin
					nxt_st.sda_rel = 1'b1;
					load = 1'b1;
					nxt_st.state = ST_STP_REL;
				end
			end
			ST_STP_REL: begin
				if (!st_ff.scl_s && !st_ff.sda_s) begin
					coll = 1'b1; // RQ4
				end else if (expire) begin
					if (!st_ff.sda_s) begin
						coll = 1'b1; // RQ3
					end else begin
						load = 1'b1;
						nxt_st.state = ST_STP_DONE;
					end
				end
				if (st_ff.sda_s && st_ff.scl_s) begin
					nxt_st.stop_seen = 1'b1; // RQ14
				end
			end
			ST_STP_DONE: begin
				if (expire) begin
					nxt_st.stop_req = 1'b0; // RQ14
					ev_set[EV_SER] = 1'b1;
					nxt_st.state = ST_IDLE;
				end
			end
			ST_XFER: begin
				// two-wire mode waits out a stretched high half, spi never does
				if (expire && !(i2c_mst && st_ff.scl_rel && !st_ff.scl_s)) begin // RQ9
					load = 1'b1; // RQ8
					nxt_st.halves = st_ff.halves + 1'b1;
					if (i2c_mst) begin
						nxt_st.scl_rel = !st_ff.scl_rel;
					end else begin
						nxt_st.sck = !st_ff.sck;
					end
					if (st_ff.halves == HALVES - 1'b1) begin
						load = 1'b0; // RQ7
						ev_set[EV_SER] = 1'b1;
						nxt_st.state = ST_IDLE;
					end
				end
			end
			default: nxt_st.state = ST_IDLE;
		endcase
		// a lost stop lets go of both lines so the winner can finish
		if (coll) begin
			ev_set[EV_COLL] = 1'b1; // RQ12
			nxt_st.sda_rel = 1'b1; // RQ13
			nxt_st.scl_rel = 1'b1;
			nxt_st.stop_req = 1'b0;
			nxt_st.state = ST_IDLE;
		end
		// disabling the port ends any sequence and clears stop seen
		if (!st_ff.enable) begin
			nxt_st.state = ST_IDLE;
			nxt_st.sda_rel = 1'b1;
			nxt_st.scl_rel = 1'b1;
			nxt_st.stop_req = 1'b0;
			nxt_st.stop_seen = 1'b0;
		end
		// hardware set wins over a same-cycle software clear
		nxt_st.evt = nxt_st.evt | ev_set;
		nxt_st.irq = |(nxt_st.evt & nxt_st.mask);
	end

	// ======================================================================
	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
			st_ff.scl_meta <= 1'b1;
			st_ff.scl_s <= 1'b1;
			st_ff.sda_meta <= 1'b1;
			st_ff.sda_s <= 1'b1;
			st_ff.mode <= MODE_RST;
			st_ff.reload <= RELOAD_RST;
			st_ff.state <= ST_IDLE;
			st_ff.scl_rel <= 1'b1;
			st_ff.sda_rel <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================================
	// outputs; open-drain pads only ever pull low
	assign prdata_o = st_ff.prdata;
	assign pready_o = st_ff.pready;
	assign pslverr_o = st_ff.pslverr;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n_o = st_ff.scl_rel;
	assign sda_oe_n_o = st_ff.sda_rel;
	assign sck_o = st_ff.sck;
	assign irq_o = st_ff.irq;

	// ======================================================================
	// checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_sda_before_scl: assert property ( // RQ1
		(st_ff.state == ST_STP_SDA && st_ff.enable) |-> !st_ff.sda_rel && !st_ff.scl_rel)
		else $error("stop released clock before data went low");
	a_scl_after_sda: assert property ( // RQ1
		(st_ff.state == ST_STP_SDA && !st_ff.sda_s && st_ff.enable) |=> st_ff.scl_rel)
		else $error("clock not released after data seen low");
	a_load_waits_high: assert property ( // RQ2
		(st_ff.state == ST_STP_SCL && !st_ff.scl_s) |=> st_ff.state != ST_STP_HIGH)
		else $error("divider loaded while clock held low");
	a_case1_coll: assert property ( // RQ3
		(st_ff.state == ST_STP_REL && expire && !st_ff.sda_s) |=>
		st_ff.evt[EV_COLL] && st_ff.state == ST_IDLE)
		else $error("low data at timeout not flagged");
	a_case2_coll: assert property ( // RQ4
		(st_ff.state == ST_STP_HIGH && !st_ff.scl_s) |=> st_ff.evt[EV_COLL])
		else $error("clock pulled low before data release not flagged");
	a_coll_release: assert property ( // RQ13
		$rose(st_ff.evt[EV_COLL]) && $past(st_ff.state) != ST_IDLE |->
		st_ff.sda_rel && st_ff.scl_rel && !st_ff.stop_req && st_ff.state == ST_IDLE)
		else $error("collision left lines or request held");
	a_stop_finish: assert property ( // RQ14
		(st_ff.state == ST_STP_DONE && expire && st_ff.enable) |=>
		!st_ff.stop_req && st_ff.evt[EV_SER] && st_ff.stop_seen)
		else $error("stop completion wrong");
	a_buf_starts: assert property ( // RQ6
		(wr_buf && st_ff.state == ST_IDLE && st_ff.enable && !stop_go &&
		(i2c_mst || spi_mst)) |=> st_ff.state == ST_XFER)
		else $error("buffer write did not start divider");
	a_clock_holds: assert property ( // RQ7
		(st_ff.state != ST_XFER) |=> $stable(st_ff.sck))
		else $error("spi clock moved while stopped");
	a_stretch_hold: assert property ( // RQ9
		(st_ff.state == ST_XFER && i2c_mst && st_ff.scl_rel && !st_ff.scl_s && expire)
		|=> $stable(st_ff.scl_rel) && $stable(st_ff.halves))
		else $error("stretched clock not honoured");
	a_irq_level: assert property ( // RQ12
		(st_ff.evt[EV_COLL] && st_ff.mask[EV_COLL]) ##1 (st_ff.evt[EV_COLL] &&
		st_ff.mask[EV_COLL]) |-> irq_o)
		else $error("interrupt low with pending collision");

	c_stop_ok: cover property (st_ff.state == ST_STP_DONE ##1 st_ff.state == ST_IDLE);
	c_stop_coll: cover property ($rose(st_ff.evt[EV_COLL]));
	c_xfer_done: cover property (st_ff.state == ST_XFER ##1 st_ff.state == ST_IDLE);
	c_wcol: cover property ($rose(st_ff.evt[EV_WCOL]));
endmodule

// ==== test/bus_peer.sv ====
// two-wire bus with pull-ups and a second party that can hold either line low
// assumes active-low enables from the block: enable low means the block pulls low
`timescale 1ns/1ps
module bus_peer (
	input wire logic scl_oe_n_i, // block pulls clock low when 0
	input wire logic sda_oe_n_i, // block pulls data low when 0
	input wire logic hold_scl_i, // peer stretches or grabs the clock
	input wire logic hold_sda_i, // peer drives a data zero
	output logic scl_o, // resolved clock line
	output logic sda_o // resolved data line
);
	// ======================================================================
	// wired-and: a released line floats high through its pull-up
	assign scl_o = scl_oe_n_i & ~hold_scl_i;
	assign sda_o = sda_oe_n_i & ~hold_sda_i;
endmodule

// ==== test/i2c_stop_collision_and_baud_gen_bench.sv ====
// self-checking bench for the stop sequence, collision checks and divider
// assumes the block answers apb in its own time and the bus peer resolves the lines
`timescale 1ns/1ps
module i2c_stop_collision_and_baud_gen_bench;
	import ssp_stop_pkg::*;
	localparam logic [31:0] I2C_ON = 32'h00000018;
	localparam logic [31:0] SPI_ON = 32'h0000001a;
	logic ref_clk, rst_n, psel, penable, pwrite, hold_scl, hold_sda;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd, prdata;
	logic pready, pslverr, scl, sda, scl_oe_n, sda_oe_n, sck, irq, err;
	int err_total = 0;
	int compares = 0;
	int n;

	// ======================================================================
	// block and far side
	ssp_stop_ctrl dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl),
		.scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n),
		.sck_o(sck), .irq_o(irq));
	bus_peer peer_u (.scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n), .hold_scl_i(hold_scl),
		.hold_sda_i(hold_sda), .scl_o(scl), .sda_o(sda));

	// 10 MHz system clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ======================================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until pready is sampled high at a rising edge; data taken there
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk(32'(pready === 1'b1), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: pick = sda_oe_n;
			1: pick = scl_oe_n;
			2: pick = irq;
			default: pick = sck;
		endcase
	endfunction

	// bounded wait for a level; running out counts as a mismatch
	task automatic wait_lvl(input int sel, input logic lvl);
		n = 0;
		while (pick(sel) !== lvl && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n < 400), 32'h1);
	endtask

	// ======================================================================
	// scenarios
	task automatic t_reset;
		logic [7:0] ra [6] = '{OFS_CTRL, OFS_SEQ, OFS_RELOAD, OFS_STAT, OFS_EVT, OFS_MASK};
		logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h9, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask

	// a slow peer stretches the clock; the divider must wait for it
	task automatic t_stop_ok;
		apb(1'b1, OFS_CTRL, I2C_ON);
		apb(1'b1, OFS_RELOAD, 32'h3);
		apb(1'b1, OFS_MASK, 32'h3);
		hold_scl <= 1'b1;
		apb(1'b1, OFS_SEQ, 32'h4);
		wait_lvl(0, 1'b0);
		repeat (20) @(negedge ref_clk);
		chk({31'h0, sda_oe_n}, 32'h0);
		@(posedge ref_clk);
		hold_scl <= 1'b0;
		wait_lvl(0, 1'b1);
		wait_lvl(2, 1'b1);
		chk(32'(n >= 16), 32'h1);
		apb(1'b0, OFS_SEQ, 32'h0);
		chk({31'h0, rd[SEQ_STOP_BIT]}, 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({31'h0, rd[STAT_STOP_BIT]}, 32'h1);
		apb(1'b0, OFS_EVT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, OFS_EVT, 32'h1);
		repeat (2) @(negedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		$display("test good stop done");
	endtask

	// peer keeps data low through the stop; interrupt masked then unmasked
	task automatic t_coll_sda;
		apb(1'b1, OFS_MASK, 32'h0);
		hold_sda <= 1'b1;
		apb(1'b1, OFS_SEQ, 32'h4);
		repeat (40) @(negedge ref_clk);
		apb(1'b0, OFS_EVT, 32'h0);
		chk(rd, 32'h2);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, OFS_SEQ, 32'h0);
		chk({31'h0, rd[SEQ_STOP_BIT]}, 32'h0);
		chk({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
		hold_sda <= 1'b0;
		apb(1'b1, OFS_MASK, 32'h2);
		repeat (2) @(negedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_EVT, 32'h2);
		repeat (2) @(negedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		$display("test data collision done");
	endtask

	// peer grabs the clock after it was seen high, before data is released
	task automatic t_coll_scl;
		apb(1'b1, OFS_RELOAD, 32'h9);
		apb(1'b1, OFS_SEQ, 32'h4);
		wait_lvl(0, 1'b0);
		repeat (10) @(posedge ref_clk);
		hold_scl <= 1'b1;
		repeat (3) @(posedge ref_clk);
		hold_scl <= 1'b0;
		repeat (10) @(negedge ref_clk);
		apb(1'b0, OFS_EVT, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, OFS_SEQ, 32'h0);
		chk({31'h0, rd[SEQ_STOP_BIT]}, 32'h0);
		chk({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
		apb(1'b1, OFS_EVT, 32'h7);
		$display("test clock collision done");
	endtask

	// buffer write runs 16 half periods of 2*(3+1) clocks, then the clock stops
	task automatic t_xfer(input logic [31:0] on, input int sel);
		int togg;
		int first;
		int last_t;
		logic last;
		togg = 0;
		first = 0;
		last_t = 0;
		apb(1'b1, OFS_CTRL, on);
		apb(1'b1, OFS_RELOAD, 32'h3);
		apb(1'b1, OFS_BUF, 32'h5a);
		last = pick(sel);
		for (int i = 0; i < 300; i++) begin
			@(negedge ref_clk);
			if (pick(sel) !== last) begin
				togg++;
				if (togg == 1) first = i;
				last_t = i;
				last = pick(sel);
			end
		end
		chk(32'(togg), 32'd16);
		chk(32'(last_t - first), 32'd120);
		apb(1'b0, OFS_EVT, 32'h0);
		chk({31'h0, rd[EV_SER]}, 32'h1);
		apb(1'b1, OFS_EVT, 32'h7);
		apb(1'b1, OFS_BUF, 32'h11);
		apb(1'b1, OFS_BUF, 32'h22);
		apb(1'b0, OFS_EVT, 32'h0);
		chk({31'h0, rd[EV_WCOL]}, 32'h1);
		repeat (300) @(negedge ref_clk);
		apb(1'b1, OFS_EVT, 32'h7);
		$display("test transfer clock done");
	endtask

	// ======================================================================
	// verdict and watchdog
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// the whole sequence needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		print_verdict();
	end

	initial begin
		{rst_n, psel, penable, pwrite, hold_scl, hold_sda} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_stop_ok();
		t_coll_sda();
		t_coll_scl();
		t_xfer(SPI_ON, 3);
		t_xfer(I2C_ON, 1);
		print_verdict();
	end
endmodule
